// *** rtl/devctl_pkg.sv ***
// constants and carrier types for the device control word block
package devctl_pkg;

  localparam logic [15:0] CTRL_ADDR = 16'h0000;
  localparam logic [15:0] CTRL_ALIAS_ADDR = 16'h0004;
  localparam logic [15:0] EXT_ADDR = 16'h0018;
  localparam logic [15:0] MAC_STAT_ADDR = 16'h0020;
  localparam logic [15:0] SPLIT_ADDR = 16'h1000;

  localparam int DUPLEX_SEL_POS = 0;
  localparam int AUTO_SPEED_POS = 5;
  localparam int LINK_UP_EN_POS = 6;
  localparam int SPEED_LSB = 8;
  localparam int FORCE_SPEED_POS = 11;
  localparam int FORCE_DUPLEX_POS = 12;
  localparam int WAKE_ADV_POS = 20;
  localparam int SOFT_RESET_POS = 26;
  localparam int RX_PAUSE_POS = 27;
  localparam int TX_PAUSE_POS = 28;
  localparam int VLAN_MODE_POS = 30;
  localparam int PHY_RESET_POS = 31;

  localparam int EXT_OVERRIDE_POS = 0;
  localparam int EXT_AUTONEG_POS = 1;
  localparam int EXT_LOW_SPEED_DIS_POS = 2;

  localparam int STAT_SPEED_LSB = 0;
  localparam int STAT_DUPLEX_POS = 2;
  localparam int STAT_LINK_POS = 3;
  localparam int STAT_WAKE_POS = 4;
  localparam int STAT_BUSY_POS = 5;
  localparam int STAT_RX_PAUSE_POS = 6;
  localparam int STAT_TX_PAUSE_POS = 7;

  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  localparam logic [1:0] SPEED_RESET = SPEED_1000;
  localparam logic WAKE_ADV_RESET = 1'h1;
  localparam logic [15:0] SPLIT_RESET = 16'h0014;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SOFT_RESET_NS = 500;
  localparam logic [3:0] SOFT_RESET_COUNT =
    4'((SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic force_speed_bit;
    logic full_duplex_select;
    logic auto_speed_detect;
    logic set_link_up;
  } nvm_image_type;

  localparam nvm_image_type NVM_RESET = '{1'h0, 1'h1, 1'h0, 1'h0};

  typedef struct packed {
    logic link;
    logic phy_duplex_indication;
    logic [1:0] speed;
    logic aux_supply_present;
    logic an_resolved;
    logic an_rx_pause;
    logic an_tx_pause;
  } phy_pins_type;

  typedef struct packed {
    logic [1:0] speed;
    logic full_duplex;
    logic link_up;
    logic rx_pause_enable;
    logic tx_pause_enable;
    logic vlan_tag_mode;
    logic carrier_extend;
    logic burst_accept;
  } mac_config_type;

endpackage

// *** rtl/soft_reset_seq.sv ***
// soft reset sequencer holding the mac reset for a fixed count
`timescale 1ns/10ps
`default_nettype none
module soft_reset_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic active
);
  import devctl_pkg::*;

  typedef struct packed {
    logic busy;
    logic [3:0] count;
  } seq_state_type;

  seq_state_type s_q;
  seq_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (!s_q.busy) begin
      if (start) begin
        s_d.busy = 1'h1;
        s_d.count = SOFT_RESET_COUNT - 4'h1;
      end
    end else if (s_q.count == 4'h0) begin
      s_d.busy = 1'h0;
    end else begin
      s_d.count = s_q.count - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active = s_q.busy;
endmodule
`default_nettype wire

// *** rtl/device_control.sv ***
// device control word register bank with mac configuration outputs
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module device_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire devctl_pkg::phy_pins_type phy_pins,
  input wire logic [1:0] asd_speed,
  input wire logic low_power_state,
  input wire logic rx_buffer_high,
  input wire logic descriptor_tag_request,
  input wire logic nvm_valid,
  input wire devctl_pkg::nvm_image_type nvm_image,
  output devctl_pkg::mac_config_type mac_config,
  output logic phy_hard_reset,
  output logic mac_soft_reset,
  output logic deep_sleep_wake_advertise,
  output logic phy_low_speed_request,
  output logic tx_tag_insert,
  output logic rx_tag_strip,
  output logic pause_on_request,
  output logic pause_off_request
);
  import devctl_pkg::*;

  typedef enum {SEL_NONE, SEL_CTRL, SEL_EXT, SEL_STAT, SEL_SPLIT} reg_sel_type;

  typedef struct packed {
    logic full_duplex_select;
    logic auto_speed_detect;
    logic set_link_up;
    logic [1:0] speed_sel;
    logic force_speed_bit;
    logic force_duplex_bit;
    logic wake_adv_enable;
    logic rx_pause_enable;
    logic tx_pause_enable;
    logic vlan_tag_mode;
    logic phy_hard_reset;
    logic speed_select_override;
    logic autoneg_enable;
    logic phy_low_speed_disable;
  } ctrl_type;

  typedef struct packed {
    phy_pins_type sync1;
    phy_pins_type sync2;
    nvm_image_type nvm;
    ctrl_type ctrl;
    logic [15:0] buf_split;
    logic link_prev;
    logic an_prev;
    logic high_prev;
    logic duplex_cap;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    mac_config_type cfg;
    logic wake_adv;
    logic low_speed_req;
    logic tag_insert;
    logic tag_strip;
    logic pause_on;
    logic pause_off;
  } state_type;

  function automatic ctrl_type ctrl_defaults(input nvm_image_type nv);
    ctrl_type c;
    c = '0;
    c.full_duplex_select = nv.full_duplex_select;
    c.auto_speed_detect = nv.auto_speed_detect;
    c.set_link_up = nv.set_link_up;
    c.force_speed_bit = nv.force_speed_bit;
    c.speed_sel = SPEED_RESET;
    c.wake_adv_enable = WAKE_ADV_RESET;
    c.phy_hard_reset = 1'h0;
    return c;
  endfunction

  function automatic reg_sel_type decode(input logic [15:0] addr);
    reg_sel_type r;
    r = SEL_NONE;
    if (addr == CTRL_ADDR || addr == CTRL_ALIAS_ADDR) begin
      r = SEL_CTRL;
    end else if (addr == EXT_ADDR) begin
      r = SEL_EXT;
    end else if (addr == MAC_STAT_ADDR) begin
      r = SEL_STAT;
    end else if (addr == SPLIT_ADDR) begin
      r = SEL_SPLIT;
    end
    return r;
  endfunction

  function automatic logic [1:0] resolve_speed(input ctrl_type c, input logic [1:0] auto_spd,
                                               input logic [1:0] phy_spd);
    logic [1:0] v;
    v = phy_spd;
    if (c.auto_speed_detect) begin
      v = auto_spd;
    end else if (c.speed_select_override) begin
      v = c.speed_sel;
    end else if (c.force_speed_bit) begin
      v = c.speed_sel;
    end
    return v;
  endfunction

  localparam state_type STATE_RESET = '{
    sync1: '0,
    sync2: '0,
    nvm: NVM_RESET,
    ctrl: '{
      full_duplex_select: NVM_RESET.full_duplex_select,
      auto_speed_detect: NVM_RESET.auto_speed_detect,
      set_link_up: NVM_RESET.set_link_up,
      speed_sel: SPEED_RESET,
      force_speed_bit: NVM_RESET.force_speed_bit,
      wake_adv_enable: WAKE_ADV_RESET,
      default: 1'h0
    },
    buf_split: SPLIT_RESET,
    cfg: '0,
    prdata: '0,
    default: 1'h0
  };

  state_type s_q;
  state_type s_d;
  logic reset_active;
  logic reset_start;
  reg_sel_type setup_sel;
  reg_sel_type access_sel;
  logic setup_phase;
  logic access_wr;
  logic link_rise;
  logic an_rise;
  logic duplex_now;
  logic [31:0] rd_word;

  soft_reset_seq u_reset_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(reset_start),
    .active(reset_active)
  );

  always_comb begin
    setup_phase = psel && !penable;
    access_wr = psel && penable && s_q.pready && pwrite;
    setup_sel = decode(paddr);
    access_sel = decode(paddr);
    reset_start = access_wr && access_sel == SEL_CTRL && pwdata[SOFT_RESET_POS];
    link_rise = s_q.sync2.link && !s_q.link_prev;
    an_rise = s_q.sync2.an_resolved && !s_q.an_prev;
    duplex_now = s_q.ctrl.force_duplex_bit ? s_q.ctrl.full_duplex_select
                                           : s_q.duplex_cap;
    rd_word = '0;
    unique case (setup_sel)
      SEL_CTRL: begin
        rd_word[DUPLEX_SEL_POS] = s_q.ctrl.full_duplex_select;
        rd_word[AUTO_SPEED_POS] = s_q.ctrl.auto_speed_detect;
        rd_word[LINK_UP_EN_POS] = s_q.ctrl.set_link_up;
        rd_word[SPEED_LSB +: 2] = s_q.ctrl.speed_sel;
        rd_word[FORCE_SPEED_POS] = s_q.ctrl.force_speed_bit;
        rd_word[FORCE_DUPLEX_POS] = s_q.ctrl.force_duplex_bit;
        rd_word[WAKE_ADV_POS] = s_q.ctrl.wake_adv_enable;
        rd_word[SOFT_RESET_POS] = reset_active;
        rd_word[RX_PAUSE_POS] = s_q.ctrl.rx_pause_enable;
        rd_word[TX_PAUSE_POS] = s_q.ctrl.tx_pause_enable;
        rd_word[VLAN_MODE_POS] = s_q.ctrl.vlan_tag_mode;
        rd_word[PHY_RESET_POS] = s_q.ctrl.phy_hard_reset;
      end
      SEL_EXT: begin
        rd_word[EXT_OVERRIDE_POS] = s_q.ctrl.speed_select_override;
        rd_word[EXT_AUTONEG_POS] = s_q.ctrl.autoneg_enable;
        rd_word[EXT_LOW_SPEED_DIS_POS] = s_q.ctrl.phy_low_speed_disable;
      end
      SEL_STAT: begin
        rd_word[STAT_SPEED_LSB +: 2] = s_q.cfg.speed;
        rd_word[STAT_DUPLEX_POS] = s_q.cfg.full_duplex;
        rd_word[STAT_LINK_POS] = s_q.cfg.link_up;
        rd_word[STAT_WAKE_POS] = s_q.wake_adv;
        rd_word[STAT_BUSY_POS] = reset_active;
        rd_word[STAT_RX_PAUSE_POS] = s_q.cfg.rx_pause_enable;
        rd_word[STAT_TX_PAUSE_POS] = s_q.cfg.tx_pause_enable;
      end
      SEL_SPLIT: begin
        rd_word[15:0] = s_q.buf_split;
      end
      SEL_NONE: begin
        rd_word = '0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;

    // pin synchronisers
    s_d.sync1 = phy_pins;
    s_d.sync2 = s_q.sync1;
    s_d.link_prev = s_q.sync2.link;
    s_d.an_prev = s_q.sync2.an_resolved;
    s_d.high_prev = rx_buffer_high;

    // apb answer, one access cycle
    s_d.pready = setup_phase;
    s_d.pslverr = setup_phase && setup_sel == SEL_NONE;
    s_d.prdata = setup_phase ? rd_word : '0;

    // duplex captured on link rising edge
    if (link_rise) begin
      s_d.duplex_cap = s_q.sync2.phy_duplex_indication;
    end

    // software writes
    if (access_wr) begin
      unique case (access_sel)
        SEL_CTRL: begin
          s_d.ctrl.full_duplex_select = pwdata[DUPLEX_SEL_POS];
          s_d.ctrl.auto_speed_detect = pwdata[AUTO_SPEED_POS];
          s_d.ctrl.set_link_up = pwdata[LINK_UP_EN_POS];
          s_d.ctrl.speed_sel = pwdata[SPEED_LSB +: 2];
          s_d.ctrl.force_speed_bit = pwdata[FORCE_SPEED_POS];
          s_d.ctrl.force_duplex_bit = pwdata[FORCE_DUPLEX_POS];
          s_d.ctrl.wake_adv_enable = pwdata[WAKE_ADV_POS];
          s_d.ctrl.rx_pause_enable = pwdata[RX_PAUSE_POS];
          s_d.ctrl.tx_pause_enable = pwdata[TX_PAUSE_POS];
          s_d.ctrl.vlan_tag_mode = pwdata[VLAN_MODE_POS];
          s_d.ctrl.phy_hard_reset = pwdata[PHY_RESET_POS];
        end
        SEL_EXT: begin
          s_d.ctrl.speed_select_override = pwdata[EXT_OVERRIDE_POS];
          s_d.ctrl.autoneg_enable = pwdata[EXT_AUTONEG_POS];
          s_d.ctrl.phy_low_speed_disable = pwdata[EXT_LOW_SPEED_DIS_POS];
        end
        SEL_SPLIT: begin
          s_d.buf_split = pwdata[15:0];
        end
        SEL_STAT, SEL_NONE: begin
          s_d.buf_split = s_q.buf_split;
        end
      endcase
    end

    // autoneg result wins over a same-cycle write
    if (s_q.ctrl.autoneg_enable && an_rise) begin
      s_d.ctrl.rx_pause_enable = s_q.sync2.an_rx_pause;
      s_d.ctrl.tx_pause_enable = s_q.sync2.an_tx_pause;
    end

    // nvm image reload of footnoted fields
    if (nvm_valid) begin
      s_d.nvm = nvm_image;
      s_d.ctrl.force_speed_bit = nvm_image.force_speed_bit;
      s_d.ctrl.full_duplex_select = nvm_image.full_duplex_select;
      s_d.ctrl.auto_speed_detect = nvm_image.auto_speed_detect;
      s_d.ctrl.set_link_up = nvm_image.set_link_up;
    end

    // mac configuration outputs
    s_d.cfg.speed = resolve_speed(s_q.ctrl, asd_speed, s_q.sync2.speed);
    s_d.cfg.full_duplex = duplex_now;
    s_d.cfg.link_up = s_q.ctrl.set_link_up && s_q.sync2.link;
    s_d.cfg.rx_pause_enable = s_q.ctrl.rx_pause_enable;
    s_d.cfg.tx_pause_enable = s_q.ctrl.tx_pause_enable;
    s_d.cfg.vlan_tag_mode = s_q.ctrl.vlan_tag_mode;
    s_d.cfg.carrier_extend = !duplex_now;
    s_d.cfg.burst_accept = !duplex_now;

    s_d.wake_adv = s_q.ctrl.wake_adv_enable && s_q.sync2.aux_supply_present;
    s_d.low_speed_req = low_power_state && !s_q.ctrl.phy_low_speed_disable;
    s_d.tag_insert = s_q.ctrl.vlan_tag_mode && descriptor_tag_request;
    s_d.tag_strip = s_q.ctrl.vlan_tag_mode;

    // pause frame requests on buffer level edges
    s_d.pause_on = s_q.ctrl.tx_pause_enable && rx_buffer_high && !s_q.high_prev;
    s_d.pause_off = s_q.ctrl.tx_pause_enable && !rx_buffer_high && s_q.high_prev;

    // soft reset: control state back to defaults, split and nvm kept
    if (reset_active) begin
      s_d.ctrl = ctrl_defaults(s_q.nvm);
      s_d.buf_split = s_q.buf_split;
      s_d.duplex_cap = 1'h0;
      s_d.link_prev = 1'h0;
      s_d.an_prev = 1'h0;
      s_d.cfg = '0;
      s_d.tag_insert = 1'h0;
      s_d.tag_strip = 1'h0;
      s_d.pause_on = 1'h0;
      s_d.pause_off = 1'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign mac_config = s_q.cfg;
  assign phy_hard_reset = s_q.ctrl.phy_hard_reset;
  assign mac_soft_reset = reset_active;
  assign deep_sleep_wake_advertise = s_q.wake_adv;
  assign phy_low_speed_request = s_q.low_speed_req;
  assign tx_tag_insert = s_q.tag_insert;
  assign rx_tag_strip = s_q.tag_strip;
  assign pause_on_request = s_q.pause_on;
  assign pause_off_request = s_q.pause_off;
endmodule
`default_nettype wire

// *** tb/device_control_sva.sv ***
// assertions on the device control block ports
`timescale 1ns/10ps
`default_nettype none
module device_control_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire devctl_pkg::phy_pins_type phy_pins,
  input wire logic low_power_state,
  input wire logic rx_buffer_high,
  input wire logic descriptor_tag_request,
  input wire logic phy_hard_reset,
  input wire logic mac_soft_reset,
  input wire logic deep_sleep_wake_advertise,
  input wire logic phy_low_speed_request,
  input wire logic tx_tag_insert,
  input wire logic rx_tag_strip,
  input wire logic pause_on_request,
  input wire logic pause_off_request
);
  import devctl_pkg::*;
  logic wr_ctrl;
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == CTRL_ADDR && !mac_soft_reset;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single access cycle");
  chk_idle_zero: assert property (!pready |-> !pslverr && prdata == 32'h0000_0000)
    else $error("response outside access cycle");
  chk_unmapped_err: assert property (pready && paddr == 16'h0100 |-> pslverr)
    else $error("unmapped access not refused");
  chk_phy_reset: assert property (wr_ctrl && !pwdata[26] |=> phy_hard_reset == $past(pwdata[31]))
    else $error("phy reset not following bit 31");
  chk_soft_len: assert property (wr_ctrl && pwdata[26] |=> mac_soft_reset[*8] ##1 mac_soft_reset
    ##1 mac_soft_reset ##1 !mac_soft_reset)
    else $error("soft reset length wrong");
  chk_tag_insert: assert property (tx_tag_insert |-> rx_tag_strip && $past(descriptor_tag_request))
    else $error("tag insert without cause");
  chk_wake_aux: assert property (!phy_pins.aux_supply_present [*6] |-> !deep_sleep_wake_advertise)
    else $error("wake advertised without aux");
  chk_low_speed: assert property (!low_power_state |=> !phy_low_speed_request)
    else $error("low speed request outside low power");
  chk_pause_pulse: assert property (pause_on_request |-> !pause_off_request &&
    $past(rx_buffer_high) ##1 !pause_on_request)
    else $error("pause on pulse wrong");
endmodule
bind device_control device_control_sva u_device_control_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .phy_pins, .low_power_state,
  .rx_buffer_high, .descriptor_tag_request, .phy_hard_reset, .mac_soft_reset,
  .deep_sleep_wake_advertise, .phy_low_speed_request, .tx_tag_insert, .rx_tag_strip,
  .pause_on_request, .pause_off_request);
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the device control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, g); \
    fails++; \
  end \
end
module tb;
  import devctl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d, e, rd;
  logic pready, pslverr, er, v;
  phy_pins_type phy_pins = '0;
  logic [1:0] asd_speed = '0, a;
  logic low_power_state = 0, rx_buffer_high = 0, descriptor_tag_request = 0, nvm_valid = 0;
  nvm_image_type nvm_image = NVM_RESET;
  mac_config_type mac_config;
  logic phy_hard_reset, mac_soft_reset, deep_sleep_wake_advertise, phy_low_speed_request;
  logic tx_tag_insert, rx_tag_strip, pause_on_request, pause_off_request;
  logic [15:0] s;
  logic [3:0] on_cnt = 0, off_cnt = 0;
  int fails = 0, checks_done = 0;
  device_control u_device_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .phy_pins, .asd_speed, .low_power_state, .rx_buffer_high,
    .descriptor_tag_request, .nvm_valid, .nvm_image, .mac_config, .phy_hard_reset,
    .mac_soft_reset, .deep_sleep_wake_advertise, .phy_low_speed_request, .tx_tag_insert,
    .rx_tag_strip, .pause_on_request, .pause_off_request);
  initial forever #25 pclk = ~pclk;
  always @(posedge pclk) begin
    on_cnt <= on_cnt + 4'(pause_on_request);
    off_cnt <= off_cnt + 4'(pause_off_request);
  end
  task automatic stop_test();
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wt(int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(logic w, logic [15:0] ad, logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [1:0] exp_spd(logic [31:0] c, logic [31:0] x, logic [1:0] asd,
                                         logic [1:0] phy);
    if (c[5]) return asd;
    if (x[0] || c[11]) return c[9:8];
    return phy;
  endfunction
  initial begin
    void'($urandom(84));
    wt(16);
    presetn <= 1'b1;
    apb(0, CTRL_ADDR, 0);
    `CHK("ctrl reset", 32'h0010_0201, rd)
    apb(0, CTRL_ALIAS_ADDR, 0);
    `CHK("alias reset", 32'h0010_0201, rd)
    apb(0, SPLIT_ADDR, 0);
    `CHK("split reset", 32'h0000_0014, rd)
    apb(0, 16'h0100, 0);
    `CHK("unmapped", 1'b1, er)
    apb(1, MAC_STAT_ADDR, '1);
    `CHK("status write", 1'b0, er)
    for (int i = 0; i < 24; i++) begin
      d = (i < 2) ? (i == 0 ? 32'hFFFF_FFFF : 0) : $urandom();
      d = d & 32'hD810_1B61;
      e = $urandom() & 32'h0000_0005;
      phy_pins.speed <= 2'($urandom());
      phy_pins.aux_supply_present <= 1'($urandom());
      asd_speed <= 2'($urandom());
      low_power_state <= 1'($urandom());
      descriptor_tag_request <= 1'($urandom());
      apb(1, EXT_ADDR, e);
      apb(1, CTRL_ADDR, d);
      apb(0, CTRL_ADDR, 0);
      `CHK("ctrl rd", d, rd)
      `CHK("speed", exp_spd(d, e, asd_speed, phy_pins.speed), mac_config.speed)
      if (d[12]) begin
        `CHK("duplex", d[0], mac_config.full_duplex)
        `CHK("carrier ext", !d[0], mac_config.carrier_extend)
        `CHK("burst", !d[0], mac_config.burst_accept)
      end
      `CHK("rx pause", d[27], mac_config.rx_pause_enable)
      `CHK("tx pause", d[28], mac_config.tx_pause_enable)
      `CHK("strip", d[30], rx_tag_strip)
      `CHK("vlan cfg", d[30], mac_config.vlan_tag_mode)
      `CHK("insert", d[30] & descriptor_tag_request, tx_tag_insert)
      `CHK("phy_hard_reset", d[31], phy_hard_reset)
      `CHK("wake", d[20] & phy_pins.aux_supply_present, deep_sleep_wake_advertise)
      `CHK("low speed", low_power_state & !e[2], phy_low_speed_request)
    end
    apb(1, CTRL_ADDR, 32'h0010_0240);
    v = 1'($urandom());
    phy_pins.phy_duplex_indication <= v;
    wt(4);
    phy_pins.link <= 1'b1;
    wt(6);
    `CHK("dup capture", v, mac_config.full_duplex)
    `CHK("link up", 1'b1, mac_config.link_up)
    phy_pins.phy_duplex_indication <= !v;
    wt(6);
    `CHK("dup held", v, mac_config.full_duplex)
    for (int k = 0; k < 2; k++) begin
      apb(1, CTRL_ADDR, k ? 32'h0010_0240 : 32'h1010_0240);
      wt(2);
      s = {on_cnt, off_cnt, 8'h00};
      rx_buffer_high <= 1'b1;
      wt(6);
      rx_buffer_high <= 1'b0;
      wt(6);
      `CHK("pause pulses", k ? 8'h00 : 8'h11, {on_cnt, off_cnt} - s[15:8])
    end
    a = 2'($urandom());
    phy_pins.an_rx_pause <= a[0];
    phy_pins.an_tx_pause <= a[1];
    apb(1, EXT_ADDR, 32'h0000_0002);
    phy_pins.an_resolved <= 1'b1;
    wt(6);
    apb(0, CTRL_ADDR, 0);
    `CHK("autoneg", a, {rd[28], rd[27]})
    nvm_image <= '{1'h1, 1'h0, 1'h0, 1'h1};
    nvm_valid <= 1'b1;
    wt(1);
    nvm_valid <= 1'b0;
    apb(0, CTRL_ADDR, 0);
    `CHK("nvm load", 4'b1100, {rd[11], rd[6], rd[5], rd[0]})
    s = 16'($urandom());
    apb(1, SPLIT_ADDR, {16'h0000, s});
    descriptor_tag_request <= 1'b0;
    apb(1, CTRL_ADDR, 32'h0400_0000);
    apb(0, MAC_STAT_ADDR, 0);
    `CHK("busy", 1'b1, rd[STAT_BUSY_POS])
    apb(0, CTRL_ADDR, 0);
    `CHK("rst bit", 1'b1, rd[26])
    `CHK("mac rst", 1'b1, mac_soft_reset)
    wt(12);
    apb(0, CTRL_ADDR, 0);
    `CHK("after rst", 32'h0010_0A40, rd)
    apb(0, SPLIT_ADDR, 0);
    `CHK("split kept", {16'h0000, s}, rd)
    stop_test();
  end
  initial begin
    wt(2000);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
